/* rtl/irq_aggr_pkg.sv */
// constants for the network adapter interrupt aggregator
// assumes a single register clock and a synchronous software reset level
package irq_aggr_pkg;

    localparam int REG_IW = 4;
    localparam logic [31:0] WORD_RESET = 32'h0000_0000;

    // register indices of the target port
    localparam logic [3:0] IDX_PENDING = 4'h0;
    localparam logic [3:0] IDX_HW_SRC = 4'h1;
    localparam logic [3:0] IDX_EN_MASK = 4'h2;
    localparam logic [3:0] IDX_GATED = 4'h3;
    localparam logic [3:0] IDX_HW_EN = 4'h4;
    localparam logic [3:0] IDX_MOD_SEL = 4'h5;
    localparam logic [3:0] IDX_HW_MOD = 4'h6;
    localparam logic [3:0] IDX_RELOAD = 4'h7;
    localparam logic [3:0] IDX_COUNT = 4'h8;
    localparam logic [3:0] IDX_COMMAND = 4'h9;
    localparam logic [3:0] IDX_SW_CTRL = 4'ha;
    localparam int IDX_USED = 11;
    localparam int IDX_SLOTS = 16;

    // main source bit positions
    localparam int BIT_HW_SUMMARY = 31;
    localparam int BIT_RESERVED = 30;
    localparam int BIT_TIMEOUT_LO = 26;
    localparam int BIT_I2C_DONE = 25;
    localparam int BIT_SW_IRQ = 24;
    localparam int BIT_EXT_SENSOR = 23;
    localparam int BIT_GEN_TIMER = 22;
    localparam int BIT_MAC1 = 21;
    localparam int BIT_LINK1_WRAP = 20;
    localparam int BIT_MAC2 = 19;
    localparam int BIT_LINK2_WRAP = 18;
    localparam int BIT_QUEUE_HI = 17;

    // hardware error source bit positions
    localparam int HWB_MASTER = 11;
    localparam int HWB_STATUS = 10;
    localparam int HWB_NO_STATUS_LO = 8;
    localparam int HWB_NO_STAMP_LO = 6;
    localparam int HWB_PARITY_HI = 5;

    // command and software control bits
    localparam int CMD_TEST_ON = 10;
    localparam int CMD_TEST_OFF = 9;
    localparam int CMD_STEP = 8;
    localparam int CMD_RUN = 2;
    localparam int CMD_HALT = 1;
    localparam int SWC_SET = 7;
    localparam int SWC_CLR = 6;

    // posted write completion and read synchronisation, in cycles
    localparam int POST_CYCLES = 2;
    localparam int SYNC_CYCLES = 2;

    typedef enum logic [1:0] {
        ACC_IDLE = 2'b00,
        ACC_POSTED = 2'b01,
        ACC_SYNC = 2'b10
    } acc_state_t;

endpackage

/* rtl/nic_interrupt_aggregator.sv */
// interrupt aggregation: sources, masks, moderation timer, INTA# drive
// assumes source levels come from logic on sys_clk, except the sensor pin
//
// Summary of operation
// RULE1: source bits read 1 while pending; writes ignored; cleared by sw reset
// RULE2: bit 31 summarises enabled hardware errors; bit 30 reads 0
// RULE3: bits 29..26 flag transfer timeouts rx1, rx2, tx1, tx2
// RULE4: bit 25 serial transfer done; bit 24 software requested interrupt
// RULE5: bit 23 follows external sensor pin; bit 22 general timer
// RULE6: bits 21/19 mac interrupts; bits 20/18 link sync counter wraps
// RULE7: bits 17..0 hold three queue bits each: end buffer, end frame, fault
// RULE8: hw error bit 11 set on master data parity, target or master abort
// RULE9: hw error bit 10 set on any of the four bus status flags
// RULE10: hw error bits 9/8 missing status, bits 7/6 missing timestamp
// RULE11: hw error bits 5..0 parity panic events; bits 31..12 read 0
// RULE12: enable mask shares source layout, 1 lets source reach INTA#
// RULE13: separate hw error enable mask, read/write, resets to 0
// RULE14: gated readback shows sources while INTA# asserted, else zero
// RULE15: gated readback during INTA# clears the enable mask only
// RULE16: moderation select mask routes 1 via timer, 0 straight to INTA#
// RULE17: hw error moderation mask selects moderated or direct per source while moderation select bit 31 is 0
// RULE18: timer reload and live count registers, 32 bits, reset 0
// RULE19: command bits 10/9 test mode on/off, bit 8 single decrement
// RULE20: command bits 2/1 run/halt countdown, halted after reset
// RULE21: software interrupt set by bit 7, cleared by bit 6, readable there
// RULE22: timer writes are posted; other timer accesses retried meanwhile
// RULE23: at count expiry, moderated pending sources assert INTA#, reload
// RULE24: both bits of a paired command written 1 leaves state unchanged
`timescale 1ns/100ps

module nic_interrupt_aggregator
    import irq_aggr_pkg::*;
#(
    parameter int POST_LAT = POST_CYCLES,
    parameter int SYNC_LAT = SYNC_CYCLES
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic sw_reset,
    input wire logic reg_req,
    input wire logic reg_write,
    input wire logic [REG_IW-1:0] reg_index,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    output logic reg_ack,
    output logic reg_retry,
    input wire logic [3:0] transfer_timeout,
    input wire logic i2c_done,
    input wire logic ext_sensor_irq,
    input wire logic general_timer_irq,
    input wire logic mac1_irq,
    input wire logic mac1_link_sync_wrap,
    input wire logic mac2_irq,
    input wire logic mac2_link_sync_wrap,
    input wire logic [17:0] queue_events,
    input wire logic bus_master_access,
    input wire logic data_parity_flag,
    input wire logic target_abort_seen_flag,
    input wire logic master_abort_seen_flag,
    input wire logic parity_detected_flag,
    input wire logic [1:0] rx_status_missing,
    input wire logic [1:0] timestamp_missing,
    input wire logic [5:0] parity_fault,
    output logic inta_out,
    output logic inta_oe
);

    function automatic logic is_timer_idx(input logic [REG_IW-1:0] idx);
        return (idx == IDX_RELOAD) || (idx == IDX_COUNT) ||
            (idx == IDX_COMMAND);
    endfunction

    // pair command: 1 on set only sets, 1 on clear only clears
    function automatic logic pair_next(input logic cur, input logic set_b,
        input logic clr_b);
        logic nxt;
        nxt = cur;
        if (set_b && !clr_b) begin
            nxt = 1'b1;
        end else if (clr_b && !set_b) begin
            nxt = 1'b0;
        end
        return nxt;
    endfunction

    logic ext_s1_q, ext_s2_q, ext_s3_q, ext_lvl_q;
    logic [31:0] src_q, hw_q;
    logic [31:0] en_q, hw_en_q, mod_q, hw_mod_q;
    logic [31:0] reload_q, cnt_q, snap_q, pend_data_q;
    logic [REG_IW-1:0] pend_idx_q, snap_idx_q;
    logic [7:0] acc_cnt_q;
    acc_state_t acc_q;
    logic snap_ok_q, sw_irq_q, test_q, run_q, mod_fire_q;
    logic [31:0] reg_rdata_q;
    logic reg_ack_q, reg_retry_q, inta_oe_q;
    // sensor pin is asynchronous: three stages, change when last two agree
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ext_s1_q <= 1'b0;
            ext_s2_q <= 1'b0;
            ext_s3_q <= 1'b0;
        end else begin
            ext_s1_q <= ext_sensor_irq;
            ext_s2_q <= ext_s1_q;
            ext_s3_q <= ext_s2_q;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ext_lvl_q <= 1'b0;
        end else if (ext_s2_q == ext_s3_q) begin
            ext_lvl_q <= ext_s3_q; // RULE5
        end
    end
    // source vectors
    wire master_err = bus_master_access & (data_parity_flag |
        target_abort_seen_flag | master_abort_seen_flag); // RULE8
    wire status_exc = parity_detected_flag | master_abort_seen_flag |
        target_abort_seen_flag | data_parity_flag; // RULE9
    wire [31:0] hw_en_src = hw_q & hw_en_q;
    wire hw_any = |hw_en_src; // RULE2
    wire [31:0] hw_d = {20'h00000, master_err, status_exc, // RULE11
        rx_status_missing, timestamp_missing, parity_fault}; // RULE10
    wire [31:0] src_d = {hw_any, 1'b0, transfer_timeout, // RULE3
        i2c_done, sw_irq_q, ext_lvl_q, general_timer_irq, // RULE4
        mac1_irq, mac1_link_sync_wrap, // RULE6
        mac2_irq, mac2_link_sync_wrap, queue_events}; // RULE7

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            src_q <= WORD_RESET;
            hw_q <= WORD_RESET;
        end else if (sw_reset) begin
            src_q <= WORD_RESET; // RULE1
            hw_q <= WORD_RESET;
        end else begin
            src_q <= src_d; // RULE1
            hw_q <= hw_d;
        end
    end
    // routing: direct sources versus those held for the moderation timer
    wire [31:0] en_src = src_q & en_q; // RULE12
    wire [30:0] low_en = en_src[30:0];
    wire direct_main = |(low_en & ~mod_q[30:0]); // RULE16
    wire moder_main = |(low_en & mod_q[30:0]);
    wire hw_gate = en_q[BIT_HW_SUMMARY];
    wire hw_direct = hw_gate & ~mod_q[BIT_HW_SUMMARY] &
        (|(hw_en_src & ~hw_mod_q)); // RULE17
    wire hw_moder = hw_gate & (mod_q[BIT_HW_SUMMARY] ? hw_any :
        (|(hw_en_src & hw_mod_q))); // RULE17
    wire direct_any = direct_main | hw_direct;
    wire moder_any = moder_main | hw_moder;
    // register port decode
    wire tmr_sel = is_timer_idx(reg_index);
    wire busy = (acc_q != ACC_IDLE);
    wire snap_hit = snap_ok_q && (snap_idx_q == reg_index);
    wire retry_now = reg_req & tmr_sel &
        (busy | (!reg_write & !snap_hit)); // RULE22
    wire take = reg_req & !retry_now;
    wire start_sync = reg_req & tmr_sel & !reg_write & !busy & !snap_hit;
    wire post_now = take & reg_write & tmr_sel; // RULE22
    wire wr_now = take & reg_write & !tmr_sel;
    wire gated_read = take & !reg_write & (reg_index == IDX_GATED) &
        inta_oe_q; // RULE15
    wire post_done = (acc_q == ACC_POSTED) && (acc_cnt_q == 8'h00);
    wire sync_done = (acc_q == ACC_SYNC) && (acc_cnt_q == 8'h00);
    // posted command word as applied
    wire cmd_apply = post_done && (pend_idx_q == IDX_COMMAND);
    wire cnt_apply = post_done && (pend_idx_q == IDX_COUNT);
    wire step_now = cmd_apply & pend_data_q[CMD_STEP]; // RULE19
    wire dec = (run_q & !test_q) | step_now;
    wire expire = dec && (cnt_q == WORD_RESET); // RULE23
    // readback table
    wire [31:0] cmd_rb = {21'h000000, test_q, !test_q, 1'b0, 5'h00,
        run_q, !run_q, 1'b0}; // RULE20
    wire [31:0] swc_rb = {24'h000000, sw_irq_q, !sw_irq_q,
        6'h00}; // RULE21
    wire [31:0] rd_tab [0:IDX_SLOTS-1];
    assign rd_tab[IDX_PENDING] = src_q;
    assign rd_tab[IDX_HW_SRC] = hw_q;
    assign rd_tab[IDX_EN_MASK] = en_q;
    assign rd_tab[IDX_GATED] = inta_oe_q ? src_q : WORD_RESET; // RULE14
    assign rd_tab[IDX_HW_EN] = hw_en_q;
    assign rd_tab[IDX_MOD_SEL] = mod_q;
    assign rd_tab[IDX_HW_MOD] = hw_mod_q;
    assign rd_tab[IDX_RELOAD] = reload_q; // RULE18
    assign rd_tab[IDX_COUNT] = cnt_q; // RULE18
    assign rd_tab[IDX_COMMAND] = cmd_rb;
    assign rd_tab[IDX_SW_CTRL] = swc_rb;
    for (genvar g = IDX_USED; g < IDX_SLOTS; g++) begin : g_unmapped
        assign rd_tab[g] = WORD_RESET;
    end
    wire [31:0] rd_sel = tmr_sel ? snap_q : rd_tab[reg_index];
    // mask registers
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            en_q <= WORD_RESET;
            hw_en_q <= WORD_RESET;
            mod_q <= WORD_RESET;
            hw_mod_q <= WORD_RESET;
        end else if (sw_reset) begin
            en_q <= WORD_RESET; // RULE12
            hw_en_q <= WORD_RESET; // RULE13
            mod_q <= WORD_RESET; // RULE16
            hw_mod_q <= WORD_RESET; // RULE17
        end else begin
            if (gated_read) begin
                en_q <= WORD_RESET; // RULE15
            end else if (wr_now && reg_index == IDX_EN_MASK) begin
                en_q <= reg_wdata; // RULE12
            end
            if (wr_now && reg_index == IDX_HW_EN) begin
                hw_en_q <= reg_wdata; // RULE13
            end
            if (wr_now && reg_index == IDX_MOD_SEL) begin
                mod_q <= reg_wdata; // RULE16
            end
            if (wr_now && reg_index == IDX_HW_MOD) begin
                hw_mod_q <= reg_wdata; // RULE17
            end
        end
    end
    // software interrupt source
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            sw_irq_q <= 1'b0;
        end else if (sw_reset) begin
            sw_irq_q <= 1'b0;
        end else if (wr_now && reg_index == IDX_SW_CTRL) begin
            sw_irq_q <= pair_next(sw_irq_q, reg_wdata[SWC_SET],
                reg_wdata[SWC_CLR]); // RULE21 RULE24
        end
    end

    // posted write and read synchronisation sequencer
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            acc_q <= ACC_IDLE;
            acc_cnt_q <= 8'h00;
            pend_idx_q <= IDX_PENDING;
            pend_data_q <= WORD_RESET;
        end else if (sw_reset) begin
            acc_q <= ACC_IDLE;
            acc_cnt_q <= 8'h00;
        end else begin
            case (acc_q)
                ACC_IDLE: begin
                    if (post_now) begin
                        acc_q <= ACC_POSTED; // RULE22
                        acc_cnt_q <= 8'(POST_LAT - 1);
                        pend_idx_q <= reg_index;
                        pend_data_q <= reg_wdata;
                    end else if (start_sync) begin
                        acc_q <= ACC_SYNC; // RULE22
                        acc_cnt_q <= 8'(SYNC_LAT - 1);
                        pend_idx_q <= reg_index;
                    end
                end
                ACC_POSTED, ACC_SYNC: begin
                    if (acc_cnt_q == 8'h00) begin
                        acc_q <= ACC_IDLE;
                    end else begin
                        acc_cnt_q <= acc_cnt_q - 8'h01;
                    end
                end
                default: begin
                    acc_q <= ACC_IDLE;
                end
            endcase
        end
    end
    // snapshot of a timer register, held until it is read
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            snap_q <= WORD_RESET;
            snap_ok_q <= 1'b0;
            snap_idx_q <= IDX_PENDING;
        end else if (sw_reset) begin
            snap_ok_q <= 1'b0;
        end else if (sync_done) begin
            snap_q <= rd_tab[pend_idx_q]; // RULE22
            snap_idx_q <= pend_idx_q;
            snap_ok_q <= 1'b1;
        end else if (take && !reg_write && tmr_sel) begin
            snap_ok_q <= 1'b0;
        end
    end

    // moderation timer
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            reload_q <= WORD_RESET;
            cnt_q <= WORD_RESET;
            test_q <= 1'b0;
            run_q <= 1'b0;
        end else if (sw_reset) begin
            reload_q <= WORD_RESET; // RULE18
            cnt_q <= WORD_RESET;
            test_q <= 1'b0;
            run_q <= 1'b0; // RULE20
        end else begin
            if (post_done && pend_idx_q == IDX_RELOAD) begin
                reload_q <= pend_data_q; // RULE18
            end
            if (cnt_apply) begin
                cnt_q <= pend_data_q; // RULE18
            end else if (expire) begin
                cnt_q <= reload_q; // RULE23
            end else if (dec) begin
                cnt_q <= cnt_q - 32'h0000_0001; // RULE19
            end
            if (cmd_apply) begin
                test_q <= pair_next(test_q, pend_data_q[CMD_TEST_ON],
                    pend_data_q[CMD_TEST_OFF]); // RULE19 RULE24
                run_q <= pair_next(run_q, pend_data_q[CMD_RUN],
                    pend_data_q[CMD_HALT]); // RULE20 RULE24
            end
        end
    end

    // moderated request holds until its pending sources are gone
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            mod_fire_q <= 1'b0;
        end else if (sw_reset) begin
            mod_fire_q <= 1'b0;
        end else if (expire && moder_any) begin
            mod_fire_q <= 1'b1; // RULE23
        end else if (!moder_any) begin
            mod_fire_q <= 1'b0;
        end
    end

    // INTA# is open drain: enable pulls the line low
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            inta_oe_q <= 1'b0;
        end else if (sw_reset) begin
            inta_oe_q <= 1'b0;
        end else begin
            inta_oe_q <= direct_any | (mod_fire_q & moder_any); // RULE12
        end
    end

    // register port answer, one cycle after the request
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            reg_ack_q <= 1'b0;
            reg_retry_q <= 1'b0;
            reg_rdata_q <= WORD_RESET;
        end else begin
            reg_ack_q <= take;
            reg_retry_q <= retry_now; // RULE22
            if (take && !reg_write) begin
                reg_rdata_q <= rd_sel; // RULE14
            end
        end
    end

    assign reg_rdata = reg_rdata_q;
    assign reg_ack = reg_ack_q;
    assign reg_retry = reg_retry_q;
    assign inta_oe = inta_oe_q;
    assign inta_out = 1'b0;

endmodule

/* test/irq_aggr_monitor.sv */
// checker of register answers, readback fields and INTA# drive
// assumes it is bound to the aggregator and sees its ports only
`timescale 1ns/100ps
module irq_aggr_monitor
    import irq_aggr_pkg::*;
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic sw_reset,
    input wire logic reg_req,
    input wire logic reg_write,
    input wire logic [REG_IW-1:0] reg_index,
    input wire logic [31:0] reg_rdata,
    input wire logic reg_ack,
    input wire logic reg_retry,
    input wire logic inta_oe
);
    wire rd = reg_req && !reg_write;
    wire tmr = reg_req && reg_index >= IDX_RELOAD && reg_index <= IDX_COMMAND;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);

    a_one_answer: assert property (reg_req |=> reg_ack != reg_retry)
        else $error("request not answered by exactly one pulse");
    a_no_answer: assert property (
        !reg_req |=> !reg_ack && !reg_retry)
        else $error("answer without a request");
    a_post_retry: assert property (
        (tmr && reg_write) ##1 (reg_ack && tmr) |=> reg_retry)
        else $error("timer access during posting not retried");
    a_bit30_zero: assert property (
        rd && reg_index == IDX_PENDING |=> !reg_rdata[BIT_RESERVED])
        else $error("reserved source bit reads one");
    a_hw_reserved: assert property (
        rd && reg_index == IDX_HW_SRC |=> reg_rdata[31:12] == 20'h0)
        else $error("reserved error source bits not zero");
    a_gated_zero: assert property (
        rd && reg_index == IDX_GATED && !inta_oe |=> reg_rdata == WORD_RESET)
        else $error("gated readback not zero while line idle");
    a_gated_clears: assert property (
        rd && reg_index == IDX_GATED && inta_oe && !sw_reset |=> ##1 !inta_oe)
        else $error("gated readback did not release the line");
    a_cmd_pairs: assert property (
        (rd && reg_index == IDX_COMMAND) ##1 reg_ack |-> !reg_rdata[8] &&
        reg_rdata[10] != reg_rdata[9] && reg_rdata[2] != reg_rdata[1])
        else $error("command readback pair malformed");
    a_swc_pair: assert property (
        rd && reg_index == IDX_SW_CTRL |=> reg_rdata[7] != reg_rdata[6])
        else $error("software interrupt readback pair malformed");
    a_reset_drop: assert property (sw_reset |=> !inta_oe)
        else $error("line still driven after software reset");
endmodule

bind nic_interrupt_aggregator irq_aggr_monitor i_irq_aggr_monitor (
    .sys_clk, .nrst, .sw_reset, .reg_req, .reg_write, .reg_index,
    .reg_rdata, .reg_ack, .reg_retry, .inta_oe);

/* test/pci_host_line.sv */
// host side of the shared interrupt line
// assumes the adapter pulls low only while its enable is high
`timescale 1ns/100ps
module pci_host_line (
    input wire logic inta_out,
    input wire logic inta_oe,
    output logic inta_n
);
    // released line rises to the pull-up level
    assign inta_n = inta_oe ? inta_out : 1'b1;
endmodule

/* test/nic_interrupt_aggregator_test.sv */
// self-checking bench for the interrupt aggregator register port
// assumes the checker binds itself and the host line model is present
`timescale 1ns/100ps
module nic_interrupt_aggregator_test
    import irq_aggr_pkg::*;
;
    logic sys_clk, nrst, sw_reset, reg_req, reg_write;
    logic [REG_IW-1:0] reg_index;
    logic [31:0] reg_wdata, reg_rdata;
    logic reg_ack, reg_retry, inta_out, inta_oe, inta_n;
    logic [3:0] transfer_timeout;
    logic i2c_done, ext_sensor_irq, general_timer_irq;
    logic mac1_irq, mac1_link_sync_wrap, mac2_irq, mac2_link_sync_wrap;
    logic [17:0] queue_events;
    logic bus_master_access, data_parity_flag, target_abort_seen_flag;
    logic master_abort_seen_flag, parity_detected_flag;
    logic [1:0] rx_status_missing, timestamp_missing;
    logic [5:0] parity_fault;
    int mismatches = 0;
    int num_checks = 0;
    localparam logic [31:0] RV [12] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
        32'h0, 32'h0, 32'h0, 32'h0, 32'h202, 32'h40, 32'h0};
    localparam logic [31:0] SP [2] = '{32'h2aaa_aaaa, 32'h1455_5555};
    localparam logic [14:0] HS [4] = '{15'h6261, 15'h119e, 15'h4800, 15'h4400};
    localparam logic [31:0] HE [4] = '{32'he61, 32'h59e, 32'hc00, 32'h400};
    localparam logic [3:0] RW [5] = '{IDX_EN_MASK, IDX_HW_EN, IDX_MOD_SEL,
        IDX_HW_MOD, IDX_RELOAD};
    localparam logic [3:0] RO [4] = '{IDX_PENDING, IDX_HW_SRC, IDX_GATED, 4'hb};

    nic_interrupt_aggregator i_nic_interrupt_aggregator (.sys_clk, .nrst,
        .sw_reset, .reg_req, .reg_write, .reg_index, .reg_wdata, .reg_rdata,
        .reg_ack, .reg_retry, .transfer_timeout, .i2c_done, .ext_sensor_irq,
        .general_timer_irq, .mac1_irq, .mac1_link_sync_wrap, .mac2_irq,
        .mac2_link_sync_wrap, .queue_events, .bus_master_access,
        .data_parity_flag, .target_abort_seen_flag, .master_abort_seen_flag,
        .parity_detected_flag, .rx_status_missing, .timestamp_missing,
        .parity_fault, .inta_out, .inta_oe);
    pci_host_line i_pci_host_line (.inta_out, .inta_oe, .inta_n);

    always #2.5 sys_clk = ~sys_clk;

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask

    task automatic acc(input logic w, input logic [3:0] i,
            input logic [31:0] d, output logic [31:0] q);
        q = 32'h0;
        for (int n = 0; n < 20; n++) begin
            @(posedge sys_clk);
            reg_req <= 1'b1;
            reg_write <= w;
            reg_index <= i;
            reg_wdata <= d;
            @(posedge sys_clk);
            reg_req <= 1'b0;
            #1;
            if (reg_ack === 1'b1) begin
                q = reg_rdata;
                return;
            end
        end
        chk(32'(reg_ack), 32'h1);
    endtask

    task automatic wr(input logic [3:0] i, input logic [31:0] d);
        logic [31:0] q;
        acc(1'b1, i, d, q);
    endtask

    task automatic rchk(input logic [3:0] i, input logic [31:0] e);
        logic [31:0] q;
        acc(1'b0, i, 32'h0, q);
        chk(q, e);
    endtask

    task automatic set_src(input logic [31:0] v);
        @(posedge sys_clk);
        {transfer_timeout, i2c_done} <= v[29:25];
        {ext_sensor_irq, general_timer_irq, mac1_irq, mac1_link_sync_wrap,
            mac2_irq, mac2_link_sync_wrap, queue_events} <= v[23:0];
        repeat (6) @(posedge sys_clk);
    endtask

    task automatic set_hw(input logic [14:0] v);
        @(posedge sys_clk);
        {bus_master_access, data_parity_flag, target_abort_seen_flag,
            master_abort_seen_flag, parity_detected_flag, rx_status_missing,
            timestamp_missing, parity_fault} <= v;
        repeat (4) @(posedge sys_clk);
    endtask

    task automatic reset_vals;
        for (int i = 0; i < 12; i++)
            rchk(4'(i), RV[i]);
    endtask

    task automatic summarize;
        if (mismatches == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        sys_clk = 1'b0;
        nrst = 1'b0;
        {sw_reset, reg_req, reg_write, reg_index, reg_wdata} = '0;
        {transfer_timeout, i2c_done, ext_sensor_irq, general_timer_irq} = '0;
        {mac1_irq, mac1_link_sync_wrap, mac2_irq, mac2_link_sync_wrap} = '0;
        {queue_events, bus_master_access, data_parity_flag} = '0;
        {target_abort_seen_flag, master_abort_seen_flag} = '0;
        {parity_detected_flag, rx_status_missing, timestamp_missing} = '0;
        parity_fault = '0;
        repeat (4) @(posedge sys_clk);
        nrst <= 1'b1;
        foreach (RO[k])
            wr(RO[k], 32'hffff_ffff);
        reset_vals();
        foreach (RW[k]) begin
            wr(RW[k], 32'ha5c3_0f96);
            rchk(RW[k], 32'ha5c3_0f96);
            wr(RW[k], 32'h0);
        end
        wr(IDX_COUNT, 32'h5a);
        rchk(IDX_COUNT, 32'h5a);
        foreach (SP[k]) begin
            set_src(SP[k]);
            rchk(IDX_PENDING, SP[k]);
        end
        set_src(32'h0);
        foreach (HS[k]) begin
            set_hw(HS[k]);
            rchk(IDX_HW_SRC, HE[k]);
        end
        set_hw(HS[0]);
        wr(IDX_HW_EN, 32'h1);
        rchk(IDX_PENDING, 32'h8000_0000);
        wr(IDX_HW_EN, 32'h2);
        rchk(IDX_PENDING, 32'h0);
        set_hw(15'h0);
        wr(IDX_SW_CTRL, 32'h80);
        wr(IDX_SW_CTRL, 32'hc0);
        rchk(IDX_SW_CTRL, 32'h80);
        rchk(IDX_PENDING, 32'h0100_0000);
        wr(IDX_HW_EN, 32'h5);
        wr(IDX_EN_MASK, 32'h0100_0000);
        repeat (3) @(posedge sys_clk);
        #1;
        chk(32'(inta_n), 32'h0);
        rchk(IDX_GATED, 32'h0100_0000);
        repeat (2) @(posedge sys_clk);
        #1;
        chk(32'(inta_n), 32'h1);
        rchk(IDX_EN_MASK, 32'h0);
        rchk(IDX_HW_EN, 32'h5);
        rchk(IDX_GATED, 32'h0);
        wr(IDX_MOD_SEL, 32'h0100_0000);
        wr(IDX_EN_MASK, 32'h0100_0000);
        repeat (8) @(posedge sys_clk);
        #1;
        chk(32'(inta_n), 32'h1);
        wr(IDX_RELOAD, 32'h10);
        wr(IDX_COUNT, 32'h2);
        repeat (2) @(posedge sys_clk);
        reg_req <= 1'b1;
        reg_write <= 1'b1;
        reg_index <= IDX_COMMAND;
        reg_wdata <= 32'h4;
        @(posedge sys_clk);
        reg_write <= 1'b0;
        reg_index <= IDX_COUNT;
        @(posedge sys_clk);
        reg_req <= 1'b0;
        #1;
        chk(32'(reg_retry), 32'h1);
        for (int k = 0; k < 40 && inta_n !== 1'b0; k++)
            @(posedge sys_clk);
        #1;
        chk(32'(inta_n), 32'h0);
        rchk(IDX_COMMAND, 32'h204);
        wr(IDX_COMMAND, 32'h6);
        rchk(IDX_COMMAND, 32'h204);
        wr(IDX_COMMAND, 32'h402);
        wr(IDX_COUNT, 32'h1);
        wr(IDX_COMMAND, 32'h100);
        rchk(IDX_COUNT, 32'h0);
        wr(IDX_COMMAND, 32'h100);
        rchk(IDX_COUNT, 32'h10);
        wr(IDX_COMMAND, 32'h600);
        rchk(IDX_COMMAND, 32'h402);
        @(posedge sys_clk);
        sw_reset <= 1'b1;
        @(posedge sys_clk);
        sw_reset <= 1'b0;
        reset_vals();
        chk(32'(inta_n), 32'h1);
        summarize();
    end

    initial begin
        #20000;
        mismatches++;
        summarize();
    end
endmodule
